// ---- src/pcr_pkg.sv ----
package pcr_pkg;
	localparam int addr_width = 8;
	localparam int data_width = 8;
	localparam logic [7:0] power_control_offset = 8'h87;
	// field positions inside the power control byte
	localparam int bit_baud_doubler = 7;
	localparam int bit_frame_error_select = 6;
	localparam int bit_reserved = 5;
	localparam int bit_power_off_flag = 4;
	localparam int bit_user_flag_one = 3;
	localparam int bit_user_flag_zero = 2;
	localparam int bit_power_down_request = 1;
	localparam int bit_idle_request = 0;
	// values after reset; the reserved bit reads as zero
	localparam logic reset_baud_doubler = 1'h0;
	localparam logic reset_frame_error_select = 1'h0;
	localparam logic reset_power_off_flag = 1'h1;
	localparam logic reset_user_flag = 1'h0;
	localparam logic reset_power_down_request = 1'h0;
	localparam logic reset_idle_request = 1'h0;
	localparam logic [7:0] reset_read_data = 8'h00;
	// clocks spent leaving power-down after a keyboard wake
	localparam int wake_clocks = 1024;
	typedef enum logic [1:0] {
		pcr_run = 2'h0,
		pcr_idle = 2'h1,
		pcr_power_down = 2'h3,
		pcr_waking = 2'h2
	} pcr_state_type;
endpackage : pcr_pkg

// ---- src/pcr_wake_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface pcr_wake_if;
	logic start;
	logic done;
	modport ctrl (output start, input done);
	modport timer (input start, output done);
endinterface : pcr_wake_if
`default_nettype wire

// ---- src/pcr_wake_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
module pcr_wake_timer #(
	parameter int count = pcr_pkg::wake_clocks
) (
	input wire logic clock, // core clock
	input wire logic rst_n, // async reset, active low
	pcr_wake_if.timer wake // start in, done out
);
	localparam int cw = $clog2(count) + 1;
	localparam logic [cw-1:0] load = cw'(count - 1);
	logic [cw-1:0] cnt;
	logic [cw-1:0] next_cnt;
	logic busy;
	logic next_busy;
	logic done;
	logic next_done;

	always_comb
	begin
		next_cnt = cnt;
		next_busy = busy;
		next_done = 1'b0;
		if (wake.start)
		begin
			next_cnt = load;
			next_busy = 1'b1;
		end
		else if (busy)
		begin
			if (cnt == '0)
			begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end
			else
				next_cnt = cnt - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			busy <= next_busy;
			done <= next_done;
		end
	end

	assign wake.done = done;
endmodule : pcr_wake_timer
`default_nettype wire

// ---- src/pcr_power_control.sv ----
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - baud doubler doubles rate in modes 1-3
// - frame error select picks mode or error bit
// - reserved bit ignored on write, reads zero
// - cold reset sets power-off flag; software clears
// - warm reset leaves power-off flag alone
// - two user flags read back last write
// - writing power-down bit enters power-down
// - any reset clears power-down bit
// - reset value reads 0001 0000 binary
// - power-down stops oscillator and watchdog
// - keyboard wake waits 1024 clocks first
// - idle keeps oscillator and watchdog running
module pcr_power_control #(
	parameter int wake_count = pcr_pkg::wake_clocks
) (
	input wire logic clock, // core clock, 250 MHz
	input wire logic rst_n, // warm reset, async, active low
	input wire logic power_on_rst_n, // cold power-on reset, async, active low
	input wire logic [pcr_pkg::addr_width-1:0] addr, // register address
	input wire logic [pcr_pkg::data_width-1:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [pcr_pkg::data_width-1:0] rdata, // read data, cycle after rd
	input wire logic [1:0] serial_mode, // serial port mode 0..3
	input wire logic serial_mode_bit_zero, // mode bit zero of serial control
	input wire logic framing_error_bit, // framing error of serial control
	input wire logic interrupt_event, // any interrupt taken, pulse
	input wire logic keyboard_wake, // keyboard interrupt, pulse or level
	output logic baud_double_active, // serial baud rate doubled
	output logic serial_ctl_bit_view, // shared serial control bit position
	output logic frame_error_view, // high when that position shows framing error
	output logic oscillator_run, // oscillator enabled
	output logic watchdog_run, // watchdog timer may count
	output logic cpu_run // core executes
);
	logic any_rst_n;
	logic hit;
	logic baud_doubler;
	logic frame_error_select;
	logic power_off_flag;
	logic user_flag_one;
	logic user_flag_zero;
	logic power_down_request;
	logic idle_request;
	logic next_baud_doubler;
	logic next_frame_error_select;
	logic next_power_off_flag;
	logic next_user_flag_one;
	logic next_user_flag_zero;
	logic next_power_down_request;
	logic next_idle_request;
	logic [pcr_pkg::data_width-1:0] next_rdata;
	pcr_pkg::pcr_state_type state;
	pcr_pkg::pcr_state_type next_state;
	logic next_start;
	logic start;

	pcr_wake_if wake ();

	// a cold reset is also a reset for every other bit
	assign any_rst_n = rst_n & power_on_rst_n;
	assign hit = (addr == pcr_pkg::power_control_offset);

	pcr_wake_timer #(
		.count(wake_count)
	) u_wake_timer (
		.clock(clock),
		.rst_n(any_rst_n),
		.wake(wake.timer)
	);
	assign wake.start = start;

	always_comb
	begin
		next_baud_doubler = baud_doubler;
		next_frame_error_select = frame_error_select;
		next_power_off_flag = power_off_flag;
		next_user_flag_one = user_flag_one;
		next_user_flag_zero = user_flag_zero;
		next_power_down_request = power_down_request;
		next_idle_request = idle_request;
		// hardware clears first, so a write in the same cycle wins
		if (interrupt_event)
			next_idle_request = 1'b0;
		if (wake.done)
			next_power_down_request = 1'b0;
		if (wr && hit)
		begin
			next_baud_doubler = wdata[pcr_pkg::bit_baud_doubler];
			next_frame_error_select = wdata[pcr_pkg::bit_frame_error_select];
			// reserved position is not stored at all
			next_power_off_flag = wdata[pcr_pkg::bit_power_off_flag];
			next_user_flag_one = wdata[pcr_pkg::bit_user_flag_one];
			next_user_flag_zero = wdata[pcr_pkg::bit_user_flag_zero];
			next_power_down_request = wdata[pcr_pkg::bit_power_down_request];
			next_idle_request = wdata[pcr_pkg::bit_idle_request];
		end
	end

	always_ff @(posedge clock or negedge any_rst_n)
	begin
		if (!any_rst_n)
		begin
			baud_doubler <= pcr_pkg::reset_baud_doubler;
			frame_error_select <= pcr_pkg::reset_frame_error_select;
			user_flag_one <= pcr_pkg::reset_user_flag;
			user_flag_zero <= pcr_pkg::reset_user_flag;
			power_down_request <= pcr_pkg::reset_power_down_request;
			idle_request <= pcr_pkg::reset_idle_request;
		end
		else
		begin
			baud_doubler <= next_baud_doubler;
			frame_error_select <= next_frame_error_select;
			user_flag_one <= next_user_flag_one;
			user_flag_zero <= next_user_flag_zero;
			power_down_request <= next_power_down_request;
			idle_request <= next_idle_request;
		end
	end

	// only power-on reaches this flop; warm reset must not touch it
	always_ff @(posedge clock or negedge power_on_rst_n)
	begin
		if (!power_on_rst_n)
			power_off_flag <= pcr_pkg::reset_power_off_flag;
		else
			power_off_flag <= next_power_off_flag;
	end

	always_comb
	begin
		next_rdata = pcr_pkg::reset_read_data;
		if (rd && hit)
		begin
			next_rdata[pcr_pkg::bit_baud_doubler] = baud_doubler;
			next_rdata[pcr_pkg::bit_frame_error_select] = frame_error_select;
			next_rdata[pcr_pkg::bit_reserved] = 1'b0;
			next_rdata[pcr_pkg::bit_power_off_flag] = power_off_flag;
			next_rdata[pcr_pkg::bit_user_flag_one] = user_flag_one;
			next_rdata[pcr_pkg::bit_user_flag_zero] = user_flag_zero;
			next_rdata[pcr_pkg::bit_power_down_request] = power_down_request;
			next_rdata[pcr_pkg::bit_idle_request] = idle_request;
		end
	end

	always_ff @(posedge clock or negedge any_rst_n)
	begin
		if (!any_rst_n)
			rdata <= pcr_pkg::reset_read_data;
		else
			rdata <= next_rdata;
	end

	// power-down takes priority when both request bits are written
	always_comb
	begin
		next_state = state;
		next_start = 1'b0;
		case (state)
			pcr_pkg::pcr_run:
			begin
				if (power_down_request)
					next_state = pcr_pkg::pcr_power_down;
				else if (idle_request)
					next_state = pcr_pkg::pcr_idle;
			end
			pcr_pkg::pcr_idle:
			begin
				if (power_down_request)
					next_state = pcr_pkg::pcr_power_down;
				else if (!idle_request)
					next_state = pcr_pkg::pcr_run;
			end
			pcr_pkg::pcr_power_down:
			begin
				if (!power_down_request)
					next_state = pcr_pkg::pcr_run;
				else if (keyboard_wake)
				begin
					next_state = pcr_pkg::pcr_waking;
					next_start = 1'b1;
				end
			end
			pcr_pkg::pcr_waking:
			begin
				if (wake.done)
					next_state = pcr_pkg::pcr_run;
			end
			default:
				next_state = pcr_pkg::pcr_run;
		endcase
	end

	always_ff @(posedge clock or negedge any_rst_n)
	begin
		if (!any_rst_n)
		begin
			state <= pcr_pkg::pcr_run;
			start <= 1'b0;
		end
		else
		begin
			state <= next_state;
			start <= next_start;
		end
	end

	// mode 0 has a fixed rate, so the doubler only acts in modes 1 to 3
	assign baud_double_active = baud_doubler && (serial_mode != 2'h0);
	assign serial_ctl_bit_view = frame_error_select ? framing_error_bit : serial_mode_bit_zero;
	assign frame_error_view = frame_error_select;
	// the oscillator stays off through power-down; it restarts for the wake delay
	assign oscillator_run = (state != pcr_pkg::pcr_power_down);
	assign watchdog_run = (state == pcr_pkg::pcr_run) || (state == pcr_pkg::pcr_idle);
	assign cpu_run = (state == pcr_pkg::pcr_run);
endmodule : pcr_power_control
`default_nettype wire

// ---- dv/pcr_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module pcr_props #(
	parameter int wake_count = 8
) (
	input wire logic clock, // core clock
	input wire logic rst_n, // warm reset
	input wire logic power_on_rst_n, // cold reset
	input wire logic [7:0] addr, // address
	input wire logic [7:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	input wire logic [7:0] rdata, // read data
	input wire logic [1:0] serial_mode, // serial mode
	input wire logic serial_mode_bit_zero, // mode bit
	input wire logic framing_error_bit, // error bit
	input wire logic interrupt_event, // interrupt
	input wire logic keyboard_wake, // wake source
	input wire logic baud_double_active, // rate doubled
	input wire logic serial_ctl_bit_view, // shared bit
	input wire logic frame_error_view, // select
	input wire logic oscillator_run, // oscillator on
	input wire logic watchdog_run, // watchdog counts
	input wire logic cpu_run // core runs
);
	logic pw;
	assign pw = wr && addr == 8'h87;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n || !power_on_rst_n);
	baud_set_a: assert property (pw && wdata[7] ##1 serial_mode != 2'h0 |-> baud_double_active)
		else $error("baud rate not doubled");
	mode_zero_a: assert property (serial_mode == 2'h0 |-> !baud_double_active)
		else $error("baud doubled in mode zero");
	bit_view_a: assert property (serial_ctl_bit_view == (frame_error_view ? framing_error_bit : serial_mode_bit_zero))
		else $error("shared serial bit wrong");
	fe_select_a: assert property (pw |=> frame_error_view == $past(wdata[6]))
		else $error("frame error select not stored");
	reserved_read_a: assert property (rd |=> !rdata[5])
		else $error("reserved bit read high");
	// the request bit lands at the write edge and the state one edge later
	pd_enter_a: assert property (pw && wdata[1] |-> ##2 !cpu_run && !oscillator_run && !watchdog_run)
		else $error("power-down not entered");
	idle_enter_a: assert property (pw && wdata[0] && !wdata[1] |-> ##2 !cpu_run && watchdog_run && oscillator_run)
		else $error("idle not entered");
	idle_exit_a: assert property (!cpu_run && watchdog_run && interrupt_event && !wr |-> ##[1:2] cpu_run)
		else $error("interrupt did not end idle");
	// the wait length here follows the bench's shortened wake count of 8
	wake_wait_a: assert property (!oscillator_run && keyboard_wake |=> !cpu_run [*8] ##[1:4] cpu_run)
		else $error("wake delay wrong");
	cover property (pw && wdata[1]);
	cover property (!oscillator_run && keyboard_wake);
	cover property (!cpu_run && watchdog_run && interrupt_event);
endmodule : pcr_props
bind pcr_power_control pcr_props #(.wake_count(wake_count)) u_props (.*);
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) \
	n_compared++; \
	if ((a) !== (e)) \
	begin \
		error_cnt++; \
		$display("CHECK FAILED %s expected %h seen %h", nm, e, a); \
	end
module tb;
	typedef struct {logic [7:0] w; logic [1:0] m; logic [7:0] r; logic b;} pcr_row_type;
	logic clock, rst_n, power_on_rst_n, wr, rd, smb0, feb, irq, kbw;
	logic [7:0] addr, wdata, rdata, v;
	logic [1:0] mode;
	logic baud, view, fev, osc, wdt, cpu;
	int error_cnt = 0;
	int n_compared = 0;
	int k;
	pcr_row_type rows [5] = '{'{8'hcc, 2'h1, 8'hcc, 1'b1}, '{8'h8c, 2'h0, 8'h8c, 1'b0},
		'{8'h80, 2'h3, 8'h80, 1'b1}, '{8'h10, 2'h2, 8'h10, 1'b0}, '{8'h44, 2'h2, 8'h44, 1'b0}};
	// short wake count keeps the power-down exit test to a few cycles
	pcr_power_control #(.wake_count(8)) dut (.clock(clock), .rst_n(rst_n), .power_on_rst_n(power_on_rst_n),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .serial_mode(mode),
		.serial_mode_bit_zero(smb0), .framing_error_bit(feb), .interrupt_event(irq), .keyboard_wake(kbw),
		.baud_double_active(baud), .serial_ctl_bit_view(view), .frame_error_view(fev),
		.oscillator_run(osc), .watchdog_run(wdt), .cpu_run(cpu));
	task automatic complete_run;
		$display("compared %0d mismatched %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	// one access, then a free cycle, so no strobe is assigned twice in one step
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : bus
	task automatic reset_pulse(input logic cold);
		@(posedge clock);
		if (cold)
			power_on_rst_n <= 1'b0;
		else
			rst_n <= 1'b0;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		power_on_rst_n <= 1'b1;
	endtask : reset_pulse
	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	initial
	begin
		#100000;
		error_cnt++;
		$display("run timed out");
		complete_run();
	end
	initial
	begin
		{rst_n, power_on_rst_n, wr, rd, smb0, irq, kbw} = '0;
		feb = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		mode = 2'h0;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		power_on_rst_n <= 1'b1;
		bus(1'b0, 8'h87, 8'h00);
		`CHK("cold reset value", 8'h10, v)
		foreach (rows[i])
		begin
			@(posedge clock);
			mode <= rows[i].m;
			bus(1'b1, 8'h87, rows[i].w);
			bus(1'b0, 8'h87, 8'h00);
			`CHK("read back", rows[i].r, v)
			`CHK("baud double", rows[i].b, baud)
			`CHK("shared bit", rows[i].w[6], view)
			`CHK("frame select", rows[i].w[6], fev)
		end
		bus(1'b1, 8'h88, 8'hff);
		bus(1'b0, 8'h88, 8'h00);
		`CHK("unmapped read", 8'h00, v)
		bus(1'b0, 8'h87, 8'h00);
		`CHK("unmapped write", 8'h44, v)
		$display("table test done");
		// power-off flag written low first, so a warm reset that set it would show
		bus(1'b1, 8'h87, 8'h06);
		@(posedge clock);
		#1;
		`CHK("power-down outputs", 3'h0, {cpu, osc, wdt})
		reset_pulse(1'b0);
		bus(1'b0, 8'h87, 8'h00);
		`CHK("warm reset value", 8'h00, v)
		`CHK("core after reset", 1'b1, cpu)
		bus(1'b1, 8'h87, 8'h00);
		reset_pulse(1'b1);
		bus(1'b0, 8'h87, 8'h00);
		`CHK("cold reset flag", 8'h10, v)
		$display("reset test done");
		bus(1'b1, 8'h87, 8'h11);
		@(posedge clock);
		#1;
		`CHK("idle outputs", 3'h3, {cpu, osc, wdt})
		@(posedge clock);
		irq <= 1'b1;
		@(posedge clock);
		irq <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		`CHK("idle left", 1'b1, cpu)
		bus(1'b0, 8'h87, 8'h00);
		`CHK("idle bit cleared", 8'h10, v)
		$display("idle test done");
		bus(1'b1, 8'h87, 8'h12);
		@(posedge clock);
		kbw <= 1'b1;
		@(posedge clock);
		kbw <= 1'b0;
		k = 0;
		while (cpu !== 1'b1 && k < 40)
		begin
			@(posedge clock);
			#1;
			k++;
		end
		`CHK("wake delay", 1'b1, k >= 7 && k <= 12)
		bus(1'b0, 8'h87, 8'h00);
		`CHK("wake clears request", 8'h10, v)
		$display("wake test done");
		complete_run();
	end
endmodule : tb
`default_nettype wire
